//--- lin_motion_command_decoder_tb.sv
// lin_motion_command_decoder_tb: self-checking bench of lmcd_top
// assumes: lmcd_lin_master as frame source, lmcd_chk bound in
`timescale 1ns/1ns
`default_nettype none
module lin_motion_command_decoder_tb
  import lmcd_pkg::*;
;
  logic        i_ref_clk = 1'b0, i_arst_n = 1'b0, i_motion_busy = 1'b0;
  logic [2:0]  pl = 3'b000;
  logic [1:0]  i_coil_fault = 2'b00;
  logic [15:0] i_pos_value = 16'h0000;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, i_rx_byte, f[9];
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        i_rx_start, i_rx_byte_valid, i_rx_end, i_rx_checksum_ok;
  logic        o_move_req, o_halt, o_shutdown, o_ref_done, o_step_loss_flag;
  logic        o_dual_busy, pready, pslverr, o_irq, err;
  logic [15:0] o_move_target, o_actual_position, o_target_position;
  logic [3:0]  o_move_vmax, o_move_vmin;
  logic [39:0] o_stall_params;
  logic [25:0] mv;
  int          n_mismatch = 0, checks = 0;

  assign mv = {o_move_req, o_dual_busy, o_move_vmax, o_move_vmin, o_move_target};
  always #2 i_ref_clk = ~i_ref_clk;

  lmcd_top i_dut (
    .i_ref_clk, .i_arst_n, .i_rx_start, .i_rx_byte_valid, .i_rx_byte, .i_rx_end,
    .i_rx_checksum_ok, .i_status_query(pl[2]), .i_coil_fault, .i_motion_busy,
    .i_move_done(pl[1]), .i_pos_valid(pl[0]), .i_pos_value, .o_move_req,
    .o_move_target, .o_move_vmax, .o_move_vmin, .o_halt, .o_shutdown,
    .o_actual_position, .o_target_position, .o_ref_done, .o_step_loss_flag,
    .o_dual_busy, .o_stall_params, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .o_irq
  );
  lmcd_lin_master i_mst (
    .i_ref_clk, .o_rx_start(i_rx_start), .o_rx_byte_valid(i_rx_byte_valid),
    .o_rx_byte(i_rx_byte), .o_rx_end(i_rx_end), .o_rx_checksum_ok(i_rx_checksum_ok)
  );

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string nm);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    do @(posedge i_ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one-cycle pulse on {query, move done, position load}
  task automatic pls(input int k);
    @(posedge i_ref_clk);
    pl[k] <= 1'b1;
    @(posedge i_ref_clk);
    pl[k] <= 1'b0;
    #1;
  endtask

  task automatic cmd3(input logic [5:0] id, input logic [6:0] c, input logic [7:0] ad);
    f[0] = i_mst.with_parity(id);
    f[1] = {1'b1, c};
    f[2] = ad;
    i_mst.send(f, 3, 0);
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic cmd9(input logic [6:0] c, input logic [7:0] ad, input logic [39:0] p);
    f = '{8'h3c, 8'h80, {1'b1, c}, ad, p[39:32], p[31:24], p[23:16], p[15:8], p[7:0]};
    i_mst.send(f, 9, 1);
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic rst();
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #8000;
    n_mismatch++;
    give_verdict();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst();
    apb(1'b0, LMCD_ADDR_IRQ_MK, 32'h0);
    chk(rd, 40'h0, "mask");
    apb(1'b0, 8'h1c, 32'h0);
    chk({err, rd}, 40'h100000000, "unmapped");
    apb(1'b1, LMCD_ADDR_CTRL, 32'h12);
    apb(1'b1, LMCD_ADDR_IRQ_MK, 32'h1f);
    $display("test registers done");
    i_pos_value <= 16'h1234;
    i_motion_busy <= 1'b1;
    pls(0);
    cmd3(6'h05, LMCD_CMD_HALT, 8'h7f);
    chk({o_halt, o_step_loss_flag}, 40'h3, "halt");
    i_motion_busy <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    chk(o_target_position, 40'h1234, "stop position");
    apb(1'b0, LMCD_ADDR_IRQ_ST, 32'h0);
    chk({o_irq, rd}, 40'h100000001, "halt irq");
    apb(1'b1, LMCD_ADDR_IRQ_ST, 32'h1);
    #1;
    chk(o_irq, 40'h0, "irq cleared");
    pls(2);
    chk(o_step_loss_flag, 40'h0, "query");
    $display("test halt done");
    cmd3(6'h11, LMCD_CMD_ZERO, 8'h85);
    chk({o_actual_position, o_ref_done}, 40'h2468, "foreign zero");
    apb(1'b0, LMCD_ADDR_IRQ_ST, 32'h0);
    chk(rd, 40'h10, "reject irq");
    cmd3(6'h2a, LMCD_CMD_ZERO, 8'h92);
    chk({o_actual_position, o_target_position, o_ref_done}, 40'h1, "zero");
    $display("test zero done");
    apb(1'b1, LMCD_ADDR_IRQ_ST, 32'h1f);
    apb(1'b1, LMCD_ADDR_IRQ_MK, 32'h0);
    cmd9(LMCD_CMD_STALL, 8'h33, 40'h1122334455);
    chk(o_stall_params, 40'h1122334455, "stall");
    apb(1'b0, LMCD_ADDR_STL_HI, 32'h0);
    chk(rd, 40'h334455, "stall high");
    apb(1'b0, LMCD_ADDR_IRQ_ST, 32'h0);
    chk({o_irq, rd}, 40'h8, "masked irq");
    apb(1'b1, LMCD_ADDR_IRQ_MK, 32'h8);
    #1;
    chk(o_irq, 40'h1, "unmasked irq");
    $display("test stall done");
    rst();
    apb(1'b1, LMCD_ADDR_CTRL, 32'h12);
    apb(1'b1, LMCD_ADDR_IRQ_MK, 32'h1f);
    cmd9(LMCD_CMD_DUAL, 8'h92, 40'ha301000020);
    chk(mv, 40'h3a30100, "leg one");
    i_pos_value <= 16'h1234;
    pls(0);
    cmd3(6'h3f, LMCD_CMD_ZERO, 8'h00);
    chk({o_actual_position, o_ref_done}, 40'h2468, "zero in two-speed");
    pls(1);
    chk(mv, 40'h3330120, "leg two");
    pls(1);
    chk({o_ref_done, o_dual_busy}, 40'h2, "two-speed end");
    apb(1'b0, LMCD_ADDR_IRQ_ST, 32'h0);
    chk(rd, 40'h4, "two-speed irq");
    $display("test two-speed done");
    i_coil_fault <= 2'b01;
    repeat (9) @(posedge i_ref_clk);
    #1;
    chk({o_shutdown, o_target_position}, 40'h11234, "coil fault");
    apb(1'b0, LMCD_ADDR_STATUS, 32'h0);
    chk(rd, 40'h5, "status");
    apb(1'b0, LMCD_ADDR_POS, 32'h0);
    chk(rd, 40'h12341234, "pos");
    i_coil_fault <= 2'b00;
    repeat (6) @(posedge i_ref_clk);
    apb(1'b1, LMCD_ADDR_CTRL, 32'h112);
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk(o_shutdown, 40'h0, "shutdown left");
    $display("test coil fault done");
    give_verdict();
  end
endmodule
`default_nettype wire

//--- lmcd_chk.sv
// lmcd_chk: port assertions for lmcd_top
// assumes: bound into lmcd_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module lmcd_chk (
  // clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_arst_n,
  // inputs
  input wire logic [1:0]  i_coil_fault,
  input wire logic        i_status_query,
  input wire logic        i_motion_busy,
  input wire logic        i_move_done,
  input wire logic        i_pos_valid,
  // outputs
  input wire logic        o_move_req,
  input wire logic [15:0] o_move_target,
  input wire logic        o_halt,
  input wire logic        o_shutdown,
  input wire logic [15:0] o_actual_position,
  input wire logic [15:0] o_target_position,
  input wire logic        o_ref_done,
  input wire logic        o_step_loss_flag,
  input wire logic        o_dual_busy
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  // ****************************************
  // assertions
  // ****************************************
  a_fault_shutdown: assert property ((i_coil_fault != 2'b00) [*8] |=> o_shutdown)
    else $error("no shutdown on coil fault");
  a_halt_step_loss_flag: assert property (
    o_halt && $past(i_motion_busy) && $past(i_motion_busy, 2) |-> o_step_loss_flag)
    else $error("step loss not set");
  a_halt_copy: assert property (
    o_halt ##1 (!i_motion_busy && !i_pos_valid) [*2] |=> o_target_position == o_actual_position)
    else $error("stop position not held");
  a_ref_sticky: assert property (o_ref_done |=> o_ref_done)
    else $error("reference done dropped");
  a_move_one_cycle: assert property (o_move_req |=> !o_move_req)
    else $error("move request too long");
  a_dual_ref_done: assert property ($fell(o_dual_busy) && !o_halt |-> o_ref_done)
    else $error("two-speed end without reference");
  a_dual_target_hold: assert property (
    o_dual_busy && !i_move_done |=> !o_dual_busy || $stable(o_move_target))
    else $error("two-speed target replaced");
  a_query_clear: assert property (i_status_query |=> !o_step_loss_flag || o_halt)
    else $error("step loss not cleared");
  c_halt_loss: cover property (o_halt && o_step_loss_flag);
  c_dual_end: cover property ($fell(o_dual_busy));
  c_shutdown: cover property ($rose(o_shutdown));
endmodule
bind lmcd_top lmcd_chk i_chk (
  .i_ref_clk, .i_arst_n, .i_coil_fault, .i_status_query, .i_motion_busy,
  .i_move_done, .i_pos_valid, .o_move_req, .o_move_target, .o_halt,
  .o_shutdown, .o_actual_position, .o_target_position, .o_ref_done,
  .o_step_loss_flag, .o_dual_busy
);
`default_nettype wire

//--- lmcd_frame_capture.sv
// lmcd_frame_capture: gathers the bytes of one received frame
// assumes: data-link layer gives start, byte and end strobes on i_ref_clk
`timescale 1ns/1ns
`default_nettype none
module lmcd_frame_capture
  import lmcd_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // byte stream
  input  wire logic        i_rx_start,
  input  wire logic        i_rx_byte_valid,
  input  wire logic [7:0]  i_rx_byte,
  input  wire logic        i_rx_end,
  input  wire logic        i_rx_checksum_ok,
  // captured frame
  output logic             o_frame_valid,
  output logic             o_frame_bad,
  output logic [3:0]       o_frame_len,
  output logic [71:0]      o_frame_bytes
);
  typedef struct packed {
    logic [LMCD_MAX_BYTES-1:0][7:0] mem;
    logic [3:0]                     cnt;
    logic                           ovf;
    logic                           ok;
    logic                           bad;
    logic [3:0]                     len;
  } lmcd_cap_t;

  lmcd_cap_t q;
  lmcd_cap_t d;

  always_comb begin
    d     = q;
    d.ok  = 1'b0;
    d.bad = 1'b0;
    if (i_rx_start) begin
      d.cnt = '0;
      d.ovf = 1'b0;
    end else if (i_rx_byte_valid) begin
      if (q.cnt < LMCD_LEN_TYPE4) begin
        d.mem[q.cnt] = i_rx_byte;
        d.cnt        = q.cnt + 4'h1;
      end else begin
        d.ovf = 1'b1;
      end
    end
    // frame accepted only with a good checksum
    if (i_rx_end && !i_rx_start) begin
      d.ok  = i_rx_checksum_ok && !q.ovf;
      d.bad = !(i_rx_checksum_ok && !q.ovf);
      d.len = q.cnt;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_frame_valid = q.ok;
  assign o_frame_bad   = q.bad;
  assign o_frame_len   = q.len;
  assign o_frame_bytes = q.mem;
endmodule
`default_nettype wire

//--- lmcd_lin_master.sv
// lmcd_lin_master: bus master side, feeds frame bytes to the decoder
// assumes: strobes change just after rising edges of i_ref_clk
`timescale 1ns/1ns
`default_nettype none
module lmcd_lin_master (
  // clock
  input  wire logic       i_ref_clk,
  // byte stream
  output logic            o_rx_start,
  output logic            o_rx_byte_valid,
  output logic [7:0]      o_rx_byte,
  output logic            o_rx_end,
  output logic            o_rx_checksum_ok
);
  initial begin
    o_rx_start = 1'b0;
    o_rx_byte_valid = 1'b0;
    o_rx_byte = 8'h00;
    o_rx_end = 1'b0;
    o_rx_checksum_ok = 1'b0;
  end

  // ****************************************
  // frame sending
  // ****************************************
  // identifier with its two parity bits on top
  function automatic logic [7:0] with_parity(input logic [5:0] id);
    return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction

  // gap idle cycles between bytes give a slow master
  task automatic send(input logic [7:0] b[9], input int n, input int gap);
    @(posedge i_ref_clk);
    o_rx_start <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge i_ref_clk);
      o_rx_start <= 1'b0;
      o_rx_byte_valid <= 1'b1;
      o_rx_byte <= b[i];
      @(posedge i_ref_clk);
      o_rx_byte_valid <= 1'b0;
      o_rx_byte <= ~b[i];
      repeat (gap) @(posedge i_ref_clk);
    end
    o_rx_end <= 1'b1;
    o_rx_checksum_ok <= 1'b1;
    @(posedge i_ref_clk);
    o_rx_end <= 1'b0;
    o_rx_checksum_ok <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- lmcd_pkg.sv
// lmcd_pkg: constants shared by the motion command decoder files
// assumes: byte-wide frame fields, 32-bit apb data, byte addresses
package lmcd_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int          LMCD_MAX_BYTES   = 9;      // identifier + 8 data bytes
  localparam logic [3:0]  LMCD_LEN_TYPE1   = 4'h3;   // identifier + 2 data bytes
  localparam logic [3:0]  LMCD_LEN_TYPE4   = 4'h9;   // identifier + 8 data bytes
  localparam logic [7:0]  LMCD_ID_DIAG     = 8'h3c;
  localparam logic [7:0]  LMCD_APP_CMD     = 8'h80;
  localparam int          LMCD_CMD_FLAG    = 7;      // bit 7 of the command byte
  localparam int          LMCD_BCAST_BIT   = 7;      // bit 7 of the address byte
  localparam logic [6:0]  LMCD_CMD_HALT    = 7'h05;
  localparam logic [6:0]  LMCD_CMD_ZERO    = 7'h06;
  localparam logic [6:0]  LMCD_CMD_DUAL    = 7'h08;
  localparam logic [6:0]  LMCD_CMD_STALL   = 7'h16;

  // ****************************************
  // apb register map
  // ****************************************
  localparam logic [7:0]  LMCD_ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  LMCD_ADDR_STATUS = 8'h04;
  localparam logic [7:0]  LMCD_ADDR_POS    = 8'h08;
  localparam logic [7:0]  LMCD_ADDR_STL_LO = 8'h0c;
  localparam logic [7:0]  LMCD_ADDR_STL_HI = 8'h10;
  localparam logic [7:0]  LMCD_ADDR_IRQ_ST = 8'h14;
  localparam logic [7:0]  LMCD_ADDR_IRQ_MK = 8'h18;

  // ctrl fields
  localparam int          LMCD_CTRL_NODE_LSB = 0;    // node address [6:0]
  localparam int          LMCD_CTRL_SDCLR    = 8;    // write 1: leave shutdown
  localparam logic [6:0]  LMCD_NODE_RST      = 7'h00;

  // status fields
  localparam int          LMCD_ST_REFDONE  = 0;
  localparam int          LMCD_ST_STEP_LOSS_FLAG = 1;
  localparam int          LMCD_ST_SHUTDOWN = 2;
  localparam int          LMCD_ST_DUAL     = 3;
  localparam int          LMCD_ST_MOVING   = 4;
  localparam int          LMCD_ST_COPYPEND = 5;

  // interrupt bits
  localparam int          LMCD_IRQ_W       = 5;
  localparam int          LMCD_IRQ_HALT    = 0;
  localparam int          LMCD_IRQ_ZERO    = 1;
  localparam int          LMCD_IRQ_DUAL    = 2;
  localparam int          LMCD_IRQ_STALL   = 3;
  localparam int          LMCD_IRQ_REJECT  = 4;
  localparam logic [4:0]  LMCD_IRQ_MK_RST  = 5'h00;

  // reset values of positions and parameters
  localparam logic [15:0] LMCD_POS_RST     = 16'h0000;
  localparam logic [39:0] LMCD_STALL_RST   = 40'h0000000000;

  // ****************************************
  // dual positioning sequence
  // ****************************************
  typedef enum logic [1:0] {LMCD_DS_IDLE, LMCD_DS_FIRST, LMCD_DS_SECOND} lmcd_dstate_t;

endpackage

//--- lmcd_sync.sv
// lmcd_sync: three-stage synchroniser for asynchronous pin levels
// assumes: a change is accepted once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module lmcd_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  // levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lv;
  } lmcd_sync_t;

  lmcd_sync_t   q;
  lmcd_sync_t   d;
  logic [W-1:0] lv_next;

  // ****************************************
  // per-bit agreement filter
  // ****************************************
  for (genvar g = 0; g < W; g++) begin : g_bit
    assign lv_next[g] = (q.s2[g] == q.s3[g]) ? q.s3[g] : q.lv[g];
  end

  always_comb begin
    d    = q;
    d.s1 = i_async;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.lv = lv_next;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_level = q.lv;
endmodule
`default_nettype wire

//--- lmcd_top.sv
// lmcd_top: motion command decoder with apb registers and interrupt
// assumes: frame bytes, motion generator strobes and apb on i_ref_clk;
// coil fault pins are asynchronous
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - coil fault raises an internal halt and enters shutdown
// - halt while moving sets the step-loss flag
// - once at rest after halt, actual position copies into target
// - two-byte commands are decoded from data bytes, never identifier
// - halt frame: command byte 0x85, then broadcast and address
// - halt with broadcast bit zero stops every node
// - zero-position command clears actual and target positions while no two-speed sequence runs
// - zero-position command sets the reference-done flag while no two-speed sequence runs
// - zero-position frame: command byte 0x86, then broadcast and address
// - two-speed frame layout: 0x3c, 0x80, 0x88, addr, speeds, two positions
// - move to first target fast, then relative offset at minimum speed
// - finished two-speed sequence sets reference-done
// - no other positioning command interrupts a running two-speed sequence
// - stall-config frame: 0x3c, 0x80, 0x96, addr, currents, speeds
// - bytes six to eight carry stall thresholds, step mode and enables
// - stall parameters kept in ram; broadcast zero applies everywhere
// - short status query clears the step-loss flag
module lmcd_top
  import lmcd_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  // frame byte stream
  input  wire logic        i_rx_start,
  input  wire logic        i_rx_byte_valid,
  input  wire logic [7:0]  i_rx_byte,
  input  wire logic        i_rx_end,
  input  wire logic        i_rx_checksum_ok,
  input  wire logic        i_status_query,
  // coil fault pins
  input  wire logic [1:0]  i_coil_fault,
  // motion generator
  input  wire logic        i_motion_busy,
  input  wire logic        i_move_done,
  input  wire logic        i_pos_valid,
  input  wire logic [15:0] i_pos_value,
  output logic             o_move_req,
  output logic [15:0]      o_move_target,
  output logic [3:0]       o_move_vmax,
  output logic [3:0]       o_move_vmin,
  output logic             o_halt,
  output logic             o_shutdown,
  output logic [15:0]      o_actual_position,
  output logic [15:0]      o_target_position,
  output logic             o_ref_done,
  output logic             o_step_loss_flag,
  output logic             o_dual_busy,
  output logic [39:0]      o_stall_params,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // interrupt
  output logic             o_irq
);
  typedef struct packed {
    lmcd_dstate_t          ds;
    logic [15:0]           actual_position;
    logic [15:0]           target_position;
    logic [15:0]           first_target;
    logic [15:0]           second_offset;
    logic [3:0]            vmax;
    logic [3:0]            vmin;
    logic                  move_req;
    logic [15:0]           move_target;
    logic [3:0]            move_vmax;
    logic [3:0]            move_vmin;
    logic                  halt;
    logic                  shutdown;
    logic                  copy_pend;
    logic                  ref_done;
    logic                  step_loss_flag;
    logic [39:0]           stall;
    logic [6:0]            node;
    logic [LMCD_IRQ_W-1:0] irq_st;
    logic [LMCD_IRQ_W-1:0] irq_mk;
    logic [31:0]           rdata;
    logic                  err;
  } lmcd_state_t;

  lmcd_state_t q;
  lmcd_state_t d;
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic        fr_valid;
  logic        fr_bad;
  logic [3:0]  fr_len;
  logic [71:0] fr_bytes;
  logic [1:0]  coil_fault;

  // ****************************************
  // reset release and submodules
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  lmcd_frame_capture u_capture (
    .i_ref_clk        (i_ref_clk),
    .i_rst_n          (rst_n),
    .i_rx_start       (i_rx_start),
    .i_rx_byte_valid  (i_rx_byte_valid),
    .i_rx_byte        (i_rx_byte),
    .i_rx_end         (i_rx_end),
    .i_rx_checksum_ok (i_rx_checksum_ok),
    .o_frame_valid    (fr_valid),
    .o_frame_bad      (fr_bad),
    .o_frame_len      (fr_len),
    .o_frame_bytes    (fr_bytes)
  );

  lmcd_sync #(.W(2)) u_fault_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_async   (i_coil_fault),
    .o_level   (coil_fault)
  );

  // ****************************************
  // frame decode
  // ****************************************
  logic [7:0] b0, b1, b2, b3, b4, b5, b6, b7, b8;
  logic       is_t1, is_t4, addr1_ok, addr4_ok;
  logic       cmd_halt, cmd_zero, cmd_dual, cmd_stall, fault_halt, halt_ev;
  logic       apb_wr, apb_setup;
  logic [LMCD_IRQ_W-1:0] irq_ev;

  assign b0 = fr_bytes[7:0];
  assign b1 = fr_bytes[15:8];
  assign b2 = fr_bytes[23:16];
  assign b3 = fr_bytes[31:24];
  assign b4 = fr_bytes[39:32];
  assign b5 = fr_bytes[47:40];
  assign b6 = fr_bytes[55:48];
  assign b7 = fr_bytes[63:56];
  assign b8 = fr_bytes[71:64];

  // identifier ignored for two-byte commands
  assign is_t1 = (fr_len == LMCD_LEN_TYPE1) && b1[LMCD_CMD_FLAG];
  // diagnostic frame header
  assign is_t4 = (fr_len == LMCD_LEN_TYPE4) && (b0 == LMCD_ID_DIAG)
              && (b1 == LMCD_APP_CMD) && b2[LMCD_CMD_FLAG];
  // broadcast zero or own address
  assign addr1_ok = !b2[LMCD_BCAST_BIT] || (b2[6:0] == q.node);
  assign addr4_ok = !b3[LMCD_BCAST_BIT] || (b3[6:0] == q.node);

  assign cmd_halt  = fr_valid && is_t1 && (b1[6:0] == LMCD_CMD_HALT) && addr1_ok;
  assign cmd_zero  = fr_valid && is_t1 && (b1[6:0] == LMCD_CMD_ZERO) && addr1_ok;
  assign cmd_dual  = fr_valid && is_t4 && (b2[6:0] == LMCD_CMD_DUAL) && addr4_ok;
  assign cmd_stall = fr_valid && is_t4 && (b2[6:0] == LMCD_CMD_STALL) && addr4_ok;

  // a fault raises a halt once, on entry to shutdown
  assign fault_halt = (|coil_fault) && !q.shutdown;
  assign halt_ev    = cmd_halt || fault_halt;

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;

  always_comb begin
    irq_ev = '0;
    irq_ev[LMCD_IRQ_HALT]   = halt_ev;
    irq_ev[LMCD_IRQ_ZERO]   = cmd_zero && (q.ds == LMCD_DS_IDLE) && !halt_ev;
    irq_ev[LMCD_IRQ_DUAL]   = (q.ds == LMCD_DS_SECOND) && i_move_done && !halt_ev;
    irq_ev[LMCD_IRQ_STALL]  = cmd_stall;
    irq_ev[LMCD_IRQ_REJECT] = fr_bad
                           || (fr_valid && !(cmd_halt || cmd_zero || cmd_dual || cmd_stall));
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d          = q;
    d.move_req = 1'b0;
    d.halt     = 1'b0;

    if (i_pos_valid) begin
      d.actual_position = i_pos_value;
    end

    // stall and motor parameters into ram
    if (cmd_stall) begin
      d.stall = {b4, b5, b6, b7, b8};
    end

    // two-speed sequence
    case (q.ds)
      LMCD_DS_IDLE: begin
        if (cmd_dual && !halt_ev) begin
          d.first_target    = {b5, b6};
          d.second_offset   = {b7, b8};
          d.vmax            = b4[7:4];
          d.vmin            = b4[3:0];
          d.move_req        = 1'b1;
          d.move_target     = {b5, b6};
          d.move_vmax       = b4[7:4];
          d.move_vmin       = b4[3:0];
          d.target_position = {b5, b6};
          d.ds              = LMCD_DS_FIRST;
        end else if (cmd_zero && !halt_ev) begin
          d.actual_position = LMCD_POS_RST;
          d.target_position = LMCD_POS_RST;
          d.ref_done        = 1'b1;
        end
      end
      LMCD_DS_FIRST: begin
        // second leg runs the offset at minimum speed
        if (i_move_done) begin
          d.move_req        = 1'b1;
          d.move_target     = q.first_target + q.second_offset;
          d.move_vmax       = q.vmin;
          d.move_vmin       = q.vmin;
          d.target_position = q.first_target + q.second_offset;
          d.ds              = LMCD_DS_SECOND;
        end
      end
      LMCD_DS_SECOND: begin
        if (i_move_done) begin
          d.ref_done = 1'b1;
          d.ds       = LMCD_DS_IDLE;
        end
      end
      default: begin
        d.ds = LMCD_DS_IDLE;
      end
    endcase
    // dual and zero commands are ignored outside idle

    // halt overrides any motion, including the two-speed sequence
    if (halt_ev) begin
      d.halt      = 1'b1;
      d.move_req  = 1'b0;
      d.ds        = LMCD_DS_IDLE;
      d.copy_pend = 1'b1;
      if (fault_halt) begin
        d.shutdown = 1'b1;
      end
      if (i_motion_busy) begin
        d.step_loss_flag = 1'b1;
      end
    end else if (q.copy_pend && !i_motion_busy && !q.halt) begin
      d.target_position = d.actual_position;
      d.copy_pend       = 1'b0;
    end

    // query clears step loss unless a new loss arrives at once
    if (i_status_query && !(halt_ev && i_motion_busy)) begin
      d.step_loss_flag = 1'b0;
    end

    // apb write in the access cycle
    if (apb_wr) begin
      case (paddr)
        LMCD_ADDR_CTRL: begin
          d.node = pwdata[LMCD_CTRL_NODE_LSB +: 7];
          if (pwdata[LMCD_CTRL_SDCLR] && !(|coil_fault)) begin
            d.shutdown = 1'b0;
          end
        end
        LMCD_ADDR_IRQ_ST: d.irq_st = q.irq_st & ~pwdata[LMCD_IRQ_W-1:0];
        LMCD_ADDR_IRQ_MK: d.irq_mk = pwdata[LMCD_IRQ_W-1:0];
        default: ;
      endcase
    end
    // set wins over write-one-to-clear
    d.irq_st = d.irq_st | irq_ev;

    // apb read data captured in the setup cycle
    if (apb_setup) begin
      d.rdata = 32'h00000000;
      d.err   = 1'b0;
      case (paddr)
        LMCD_ADDR_CTRL:   d.rdata[6:0] = q.node;
        LMCD_ADDR_STATUS: begin
          d.rdata[LMCD_ST_REFDONE]  = q.ref_done;
          d.rdata[LMCD_ST_STEP_LOSS_FLAG] = q.step_loss_flag;
          d.rdata[LMCD_ST_SHUTDOWN] = q.shutdown;
          d.rdata[LMCD_ST_DUAL]     = (q.ds != LMCD_DS_IDLE);
          d.rdata[LMCD_ST_MOVING]   = i_motion_busy;
          d.rdata[LMCD_ST_COPYPEND] = q.copy_pend;
        end
        LMCD_ADDR_POS:    d.rdata = {q.target_position, q.actual_position};
        LMCD_ADDR_STL_LO: d.rdata[15:0] = q.stall[39:24];
        LMCD_ADDR_STL_HI: d.rdata[23:0] = q.stall[23:0];
        LMCD_ADDR_IRQ_ST: d.rdata[LMCD_IRQ_W-1:0] = q.irq_st;
        LMCD_ADDR_IRQ_MK: d.rdata[LMCD_IRQ_W-1:0] = q.irq_mk;
        default:          d.err = 1'b1;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q                 <= '0;
      q.ds              <= LMCD_DS_IDLE;
      q.actual_position <= LMCD_POS_RST;
      q.target_position <= LMCD_POS_RST;
      q.stall           <= LMCD_STALL_RST;
      q.node            <= LMCD_NODE_RST;
      q.irq_mk          <= LMCD_IRQ_MK_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_move_req        = q.move_req;
  assign o_move_target     = q.move_target;
  assign o_move_vmax       = q.move_vmax;
  assign o_move_vmin       = q.move_vmin;
  assign o_halt            = q.halt;
  assign o_shutdown        = q.shutdown;
  assign o_actual_position = q.actual_position;
  assign o_target_position = q.target_position;
  assign o_ref_done        = q.ref_done;
  assign o_step_loss_flag  = q.step_loss_flag;
  assign o_dual_busy       = (q.ds != LMCD_DS_IDLE);
  assign o_stall_params    = q.stall;
  assign pready            = 1'b1;
  assign prdata            = q.rdata;
  assign pslverr           = q.err && psel && penable;
  assign o_irq             = |(q.irq_st & q.irq_mk);
endmodule
`default_nettype wire
